// File: rtl/uart_line_modem_status.sv
/*
  Line and modem status, scratch, level readout, hysteresis and prescaler
  for one serial channel, behind an AHB-Lite slave with zero wait states.
  Assumes receiver and transmitter pulses are synchronous to hclk.
*/
`timescale 1ns/1ps
module uart_line_modem_status #(
  parameter int RX_DEPTH = 128
) (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  input wire uart_status_pkg::rx_event_type rx, // Receiver events
  input wire uart_status_pkg::tx_status_type tx, // Transmitter status
  input wire uart_status_pkg::modem_pins_type pins, // Modem inputs
  input wire logic rx_line, // Serial input level
  input wire logic fifo_enable, // FIFO mode
  output logic baud_tick, // Baud generator enable
  output logic line_irq, // Line status interrupt
  output logic modem_irq, // Modem status interrupt
  output logic tx_stop, // Hold transmitter
  output logic dtr_n, // Data terminal ready pin
  output logic rts_n, // Request to send pin
  output logic op2_n, // General output two
  output logic loopback_on, // Local loopback active
  output logic [5:0] rts_hysteresis // Hysteresis in characters
);
  localparam int PTR_W = $clog2(RX_DEPTH);
  localparam logic [7:0] DEPTH_COUNT = 8'(RX_DEPTH);

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic [7:0] modem_control;
  logic [7:0] int_enable;
  logic [7:0] feature_control;
  logic [7:0] enhanced_feature;
  logic [7:0] scratch_pad;
  logic [7:0] mode_select;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] read_mux;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic [7:0] level_value;
  logic [7:0] rx_count;
  logic [7:0] err_count;
  logic [3:0] delta;
  logic alt_tx;
  logic accept;
  logic rd_line;
  logic rd_modem;
  logic rd_level;
  logic wr_enhanced_mode_select;
  logic swap;

  assign accept = hsel && htrans[1] && hready;
  assign swap = feature_control[uart_status_pkg::FC_SWAP];
  assign rd_line = accept && !hwrite && haddr[7:0] == uart_status_pkg::ADDR_LINE_STATUS;
  assign rd_modem = accept && !hwrite && haddr[7:0] == uart_status_pkg::ADDR_MODEM_STATUS;
  assign rd_level = accept && !hwrite && swap
    && haddr[7:0] == uart_status_pkg::ADDR_SCRATCH;
  assign wr_enhanced_mode_select = wr_pend && swap && wr_addr == uart_status_pkg::ADDR_SCRATCH;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= accept && hwrite;
      wr_addr <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_comb
  begin
    read_mux = uart_status_pkg::ZERO_BYTE;
    if (haddr[7:0] == uart_status_pkg::ADDR_LINE_STATUS)
      read_mux = line_status;
    else if (haddr[7:0] == uart_status_pkg::ADDR_MODEM_STATUS)
      read_mux = modem_status;
    else if (haddr[7:0] == uart_status_pkg::ADDR_SCRATCH)
      read_mux = swap ? level_value : scratch_pad;
    else if (haddr[7:0] == uart_status_pkg::ADDR_MODEM_CONTROL)
      read_mux = modem_control;
    else if (haddr[7:0] == uart_status_pkg::ADDR_INT_ENABLE)
      read_mux = int_enable;
    else if (haddr[7:0] == uart_status_pkg::ADDR_FEATURE_CONTROL)
      read_mux = feature_control;
    else if (haddr[7:0] == uart_status_pkg::ADDR_ENHANCED_FEATURE)
      read_mux = enhanced_feature;
    else if (haddr[7:0] == uart_status_pkg::ADDR_HYSTERESIS)
      read_mux = {2'b00, rts_hysteresis};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (accept && !hwrite)
      hrdata <= {24'h00_0000, read_mux};
  end

  // Writable registers; the scratch byte has no sleep reset path.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      modem_control <= 8'h00;
      int_enable <= 8'h00;
      feature_control <= 8'h00;
      enhanced_feature <= 8'h00;
      scratch_pad <= uart_status_pkg::SCRATCH_RESET;
      mode_select <= 8'h00;
    end
    else if (wr_pend)
    begin
      if (wr_addr == uart_status_pkg::ADDR_MODEM_CONTROL)
        modem_control <= hwdata[7:0];
      else if (wr_addr == uart_status_pkg::ADDR_INT_ENABLE)
        int_enable <= hwdata[7:0];
      else if (wr_addr == uart_status_pkg::ADDR_FEATURE_CONTROL)
        feature_control <= hwdata[7:0];
      else if (wr_addr == uart_status_pkg::ADDR_ENHANCED_FEATURE)
        enhanced_feature <= hwdata[7:0];
      else if (wr_enhanced_mode_select)
        mode_select <= hwdata[7:0];
      else if (wr_addr == uart_status_pkg::ADDR_SCRATCH)
        scratch_pad <= hwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // Receive error tags
  // ------------------------------------------------------------
  logic [2:0] tag_mem [RX_DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [2:0] new_tag;
  logic [2:0] head_tag;
  logic rx_full;
  logic push_ok;
  logic pop_ok;
  logic break_held;
  logic overrun;
  logic drop_break;

  assign new_tag = {rx.break_err, rx.framing_err, rx.parity_err};
  assign rx_full = fifo_enable ? rx_count == DEPTH_COUNT : rx_count != 8'h00;
  assign drop_break = fifo_enable && rx.break_err && break_held;
  assign push_ok = rx.push && !rx_full && !drop_break;
  assign pop_ok = rx.pop && rx_count != 8'h00;
  assign head_tag = rx_count != 8'h00 ? tag_mem[rd_ptr] : 3'b000;

  for (genvar i = 0; i < RX_DEPTH; i++)
  begin : g_tag
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        tag_mem[i] <= 3'b000;
      else if (push_ok && wr_ptr == PTR_W'(i))
        tag_mem[i] <= new_tag;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      rx_count <= 8'h00;
    end
    else
    begin
      if (push_ok)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop_ok)
        rd_ptr <= rd_ptr + 1'b1;
      if (push_ok && !pop_ok)
        rx_count <= rx_count + 8'h01;
      else if (pop_ok && !push_ok)
        rx_count <= rx_count - 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      err_count <= 8'h00;
    else if ((push_ok && |new_tag) && !(pop_ok && |head_tag))
      err_count <= err_count + 8'h01;
    else if (!(push_ok && |new_tag) && (pop_ok && |head_tag))
      err_count <= err_count - 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      break_held <= 1'b0;
    else if (rx.push && rx.break_err)
      break_held <= 1'b1;
    else if (rx_line)
      break_held <= 1'b0;
  end

  // overrun flag, set wins over read clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      overrun <= 1'b0;
    else if (rx.push && rx_full)
      overrun <= 1'b1;
    else if (rd_line)
      overrun <= 1'b0;
  end

  // ------------------------------------------------------------
  // Transmit flags and line status
  // ------------------------------------------------------------
  logic thr_flag;
  logic thr_empty;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      thr_flag <= 1'b1;
    else if (tx.holding_load)
      thr_flag <= 1'b0;
    else if (tx.holding_move)
      thr_flag <= 1'b1;
  end

  assign thr_empty = fifo_enable ? tx.level == 8'h00 : thr_flag;

  assign line_status = {err_count != 8'h00, thr_empty && !tx.shifter_busy, thr_empty,
    head_tag, overrun, rx_count != 8'h00};

  // ------------------------------------------------------------
  // Modem status
  // ------------------------------------------------------------
  logic [3:0] msr_now;
  logic [3:0] msr_prev;
  logic [3:0] delta_set;
  logic loop_mode;

  assign loop_mode = modem_control[uart_status_pkg::MC_LOOP];
  assign msr_now = loop_mode
    ? {modem_control[uart_status_pkg::MC_OUT2], modem_control[uart_status_pkg::MC_OUT1],
       modem_control[uart_status_pkg::MC_DTR], modem_control[uart_status_pkg::MC_RTS]}
    : ~{pins.cd_n, pins.ri_n, pins.dsr_n, pins.cts_n};
  assign delta_set = {msr_now[3] ^ msr_prev[3], msr_prev[2] && !msr_now[2],
    msr_now[1:0] ^ msr_prev[1:0]};
  assign modem_status = {msr_now, delta};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      msr_prev <= 4'h0;
      delta <= 4'h0;
    end
    else
    begin
      msr_prev <= msr_now;
      delta <= (delta & ~{4{rd_modem}}) | delta_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      line_irq <= 1'b0;
      modem_irq <= 1'b0;
    end
    else
    begin
      line_irq <= int_enable[uart_status_pkg::IE_LINE] && (overrun || err_count != 8'h00);
      modem_irq <= int_enable[uart_status_pkg::IE_MODEM] && |delta;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tx_stop <= 1'b0;
    else if (!enhanced_feature[uart_status_pkg::EF_AUTO_CTS] || msr_now[0])
      tx_stop <= 1'b0;
    else if (tx.char_end || !tx.shifter_busy)
      tx_stop <= 1'b1;
  end

  // ------------------------------------------------------------
  // Level readout and hysteresis
  // ------------------------------------------------------------
  // counter source
  always_comb
  begin
    level_value = rx_count;
    if (mode_select[1:0] == uart_status_pkg::MODE_TX)
      level_value = tx.level;
    else if (mode_select[1:0] == uart_status_pkg::MODE_ALT && alt_tx)
      level_value = tx.level;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      alt_tx <= 1'b0;
    else if (wr_enhanced_mode_select)
      alt_tx <= 1'b0;
    else if (rd_level && mode_select[1:0] == uart_status_pkg::MODE_ALT)
      alt_tx <= !alt_tx;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rts_hysteresis <= 6'h00;
    else
      rts_hysteresis <= uart_status_pkg::HYST_TABLE[
        {mode_select[5:4], feature_control[1:0]} * 6 +: 6];
  end

  // ------------------------------------------------------------
  // Prescaler and modem outputs
  // ------------------------------------------------------------
  logic [1:0] pre_count;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_count <= 2'h0;
      baud_tick <= 1'b0;
    end
    else
    begin
      pre_count <= pre_count + 2'h1;
      baud_tick <= !modem_control[uart_status_pkg::MC_PRESCALE]
        || pre_count == uart_status_pkg::PRESCALE_LAST;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      op2_n <= 1'b1;
      loopback_on <= 1'b0;
    end
    else
    begin
      dtr_n <= !modem_control[uart_status_pkg::MC_DTR] || loop_mode;
      rts_n <= !modem_control[uart_status_pkg::MC_RTS] || loop_mode;
      op2_n <= !modem_control[uart_status_pkg::MC_OUT2] || loop_mode;
      loopback_on <= loop_mode;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_prescale;
    @(posedge hclk) disable iff (!hresetn)
    modem_control[uart_status_pkg::MC_PRESCALE] [*5] |-> !(baud_tick && $past(baud_tick));
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler ticks too often");

  property p_line_irq;
    @(posedge hclk) disable iff (!hresetn)
    int_enable[uart_status_pkg::IE_LINE] && overrun |=> line_irq;
  endproperty
  a_line_irq: assert property (p_line_irq) else $error("line interrupt missing");

  property p_ready;
    @(posedge hclk) disable iff (!hresetn)
    push_ok |=> line_status[0];
  endproperty
  a_ready: assert property (p_ready) else $error("data ready wrong");

  property p_overrun;
    @(posedge hclk) disable iff (!hresetn)
    rx.push && rx_full && !rx.pop |=> overrun && rx_count == $past(rx_count);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not handled");

  property p_fifo_err;
    @(posedge hclk) disable iff (!hresetn)
    push_ok && |new_tag && !pop_ok |=> line_status[7];
  endproperty
  a_fifo_err: assert property (p_fifo_err) else $error("queue error flag missing");

  property p_ring_rise;
    @(posedge hclk) disable iff (!hresetn)
    !loop_mode && !$past(loop_mode) && $rose(pins.ri_n) |=> delta[2];
  endproperty
  a_ring_rise: assert property (p_ring_rise) else $error("ring delta missed");

  property p_ring_fall;
    @(posedge hclk) disable iff (!hresetn)
    !delta[2] && !loop_mode && !$past(loop_mode) && $fell(pins.ri_n) |=> !delta[2];
  endproperty
  a_ring_fall: assert property (p_ring_fall) else $error("ring delta on fall");

  property p_msr_clear;
    @(posedge hclk) disable iff (!hresetn)
    rd_modem && delta_set == 4'h0 |=> delta == 4'h0;
  endproperty
  a_msr_clear: assert property (p_msr_clear) else $error("deltas not cleared");

  property p_cts_resume;
    @(posedge hclk) disable iff (!hresetn)
    msr_now[0] |=> !tx_stop;
  endproperty
  a_cts_resume: assert property (p_cts_resume) else $error("transmitter not resumed");

  property p_swap_keep;
    @(posedge hclk) disable iff (!hresetn)
    wr_enhanced_mode_select |=> scratch_pad == $past(scratch_pad);
  endproperty
  a_swap_keep: assert property (p_swap_keep) else $error("scratch written under swap");

  property p_alt_first;
    @(posedge hclk) disable iff (!hresetn)
    rd_level && mode_select[1:0] == uart_status_pkg::MODE_ALT && !alt_tx
      |=> hrdata[7:0] == $past(rx_count);
  endproperty
  a_alt_first: assert property (p_alt_first) else $error("alternate read not receive");
endmodule

// File: rtl/uart_status_pkg.sv
/*
  Constants, field positions and carriers for the channel status block.
  Assumes a 32-bit AHB-Lite register bus with one word per register.
*/
package uart_status_pkg;
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MODEM_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SCRATCH = 8'h08;
  localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h0c;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_FEATURE_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_ENHANCED_FEATURE = 8'h18;
  localparam logic [7:0] ADDR_HYSTERESIS = 8'h1c;
  localparam logic [7:0] SCRATCH_RESET = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_LOOP = 4;
  localparam int MC_PRESCALE = 7;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;
  localparam int FC_SWAP = 6;
  localparam int EF_AUTO_CTS = 7;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam logic [1:0] MODE_TX = 2'h1;
  localparam logic [1:0] MODE_ALT = 2'h3;
  localparam logic [95:0] HYST_TABLE = {
    6'h24, 6'h1c, 6'h14, 6'h0c, 6'h34, 6'h30, 6'h2c, 6'h28,
    6'h20, 6'h18, 6'h10, 6'h08, 6'h08, 6'h06, 6'h04, 6'h00};
  typedef struct packed {
    logic push;
    logic pop;
    logic parity_err;
    logic framing_err;
    logic break_err;
  } rx_event_type;
  typedef struct packed {
    logic holding_load;
    logic holding_move;
    logic shifter_busy;
    logic char_end;
    logic [7:0] level;
  } tx_status_type;
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic ri_n;
    logic cd_n;
  } modem_pins_type;
endpackage

// File: testbench/far_end_model.sv
/*
  Far-side model of one channel: receiver events, transmitter status,
  modem pins and the serial input level.
  Assumes the bench calls its tasks just after a rising edge of hclk.
*/
`timescale 1ns/1ps
module far_end_model (
  input wire logic hclk, // Bus clock
  output uart_status_pkg::rx_event_type rx, // Receiver events
  output uart_status_pkg::tx_status_type tx, // Transmitter status
  output uart_status_pkg::modem_pins_type pins, // Modem inputs
  output logic rx_line // Serial input level
);
  initial
  begin
    rx = '0;
    tx = '0;
    pins = 4'hf;
    rx_line = 1'b1;
  end

  // Error bits are parity, framing, break; they travel with the push.
  task automatic push(input logic [2:0] err);
    @(posedge hclk);
    rx <= {2'b10, err};
    @(posedge hclk);
    rx <= '0;
  endtask

  task automatic pop();
    @(posedge hclk);
    rx <= 5'b01000;
    @(posedge hclk);
    rx <= '0;
  endtask

  // Event bits are holding load, holding move, character end.
  task automatic tx_pulse(input logic [2:0] ev);
    @(posedge hclk);
    tx.holding_load <= ev[2];
    tx.holding_move <= ev[1];
    tx.char_end <= ev[0];
    @(posedge hclk);
    tx.holding_load <= 1'b0;
    tx.holding_move <= 1'b0;
    tx.char_end <= 1'b0;
  endtask

  task automatic set_tx(input logic busy, input logic [7:0] lvl);
    tx.shifter_busy <= busy;
    tx.level <= lvl;
  endtask

  task automatic set_pins(input logic [3:0] p);
    pins <= p;
  endtask

  task automatic set_line(input logic l);
    rx_line <= l;
  endtask
endmodule

// File: testbench/tb.sv
/*
  Self-checking bench for the channel status block.
  Assumes the block's package is compiled first and the far-side model beside it.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] LS = uart_status_pkg::ADDR_LINE_STATUS;
  localparam logic [7:0] MS = uart_status_pkg::ADDR_MODEM_STATUS;
  localparam logic [7:0] SP = uart_status_pkg::ADDR_SCRATCH;
  localparam logic [7:0] MC = uart_status_pkg::ADDR_MODEM_CONTROL;
  localparam logic [7:0] IE = uart_status_pkg::ADDR_INT_ENABLE;
  localparam logic [7:0] FC = uart_status_pkg::ADDR_FEATURE_CONTROL;
  localparam logic [7:0] EF = uart_status_pkg::ADDR_ENHANCED_FEATURE;
  logic hclk, hresetn, hsel, hwrite, fifo_enable;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hready, hreadyout, hresp, baud_tick, line_irq, modem_irq, tx_stop;
  logic dtr_n, rts_n, op2_n, loopback_on, rx_line;
  logic [31:0] hrdata, rd;
  logic [5:0] rts_hysteresis;
  uart_status_pkg::rx_event_type rx;
  uart_status_pkg::tx_status_type tx;
  uart_status_pkg::modem_pins_type pins;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [5:0] hyst [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
    6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24};

  always #10 hclk = ~hclk;
  assign hready = hreadyout;

  uart_line_modem_status #(.RX_DEPTH(4)) u_uart_line_modem_status (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx(rx), .tx(tx),
    .pins(pins), .rx_line(rx_line), .fifo_enable(fifo_enable), .baud_tick(baud_tick),
    .line_irq(line_irq), .modem_irq(modem_irq), .tx_stop(tx_stop), .dtr_n(dtr_n),
    .rts_n(rts_n), .op2_n(op2_n), .loopback_on(loopback_on),
    .rts_hysteresis(rts_hysteresis));

  far_end_model u_far_end_model (.hclk(hclk), .rx(rx), .tx(tx), .pins(pins),
    .rx_line(rx_line));

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task automatic wrap_up();
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One single word transfer; read data lands in rd.
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hsize <= 3'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(rd & {24'h00_0000, m}, {24'h00_0000, e});
  endtask

  task automatic ticks(output int n);
    n = 0;
    repeat (8)
    begin
      @(posedge hclk);
      if (baud_tick === 1'b1)
        n++;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdm(SP, 8'hff, 8'hff);
    wr(SP, 8'h5a);
    rdm(SP, 8'hff, 8'h5a);
    bus(8'h40, 1'b0, 8'h00);
    chk(rd, 32'h0000_0000);
    chk(hresp, 1'b0);
  endtask

  task automatic t_rx();
    wr(IE, 8'h04);
    u_far_end_model.push(3'b100);
    u_far_end_model.push(3'b000);
    rdm(LS, 8'h9f, 8'h85);
    chk(line_irq, 1'b1);
    u_far_end_model.pop();
    rdm(LS, 8'h9f, 8'h01);
    chk(line_irq, 1'b0);
    u_far_end_model.pop();
    u_far_end_model.push(3'b010);
    rdm(LS, 8'h9f, 8'h89);
    u_far_end_model.pop();
    rdm(LS, 8'h9f, 8'h00);
  endtask

  task automatic t_level();
    repeat (5) u_far_end_model.push(3'b000);
    rdm(LS, 8'h9f, 8'h03);
    rdm(LS, 8'h9f, 8'h01);
    wr(FC, 8'h40);
    u_far_end_model.set_tx(1'b0, 8'h07);
    wr(SP, 8'h00);
    rdm(SP, 8'hff, 8'h04);
    wr(SP, 8'h01);
    rdm(SP, 8'hff, 8'h07);
    wr(SP, 8'h02);
    rdm(SP, 8'hff, 8'h04);
    wr(SP, 8'h03);
    rdm(SP, 8'hff, 8'h04);
    rdm(SP, 8'hff, 8'h07);
    rdm(SP, 8'hff, 8'h04);
    repeat (4) u_far_end_model.pop();
    wr(SP, 8'h00);
    rdm(SP, 8'hff, 8'h00);
    wr(FC, 8'h00);
    rdm(SP, 8'hff, 8'h5a);
    u_far_end_model.set_tx(1'b0, 8'h00);
  endtask

  task automatic t_break();
    wr(FC, 8'h40);
    wr(SP, 8'h00);
    u_far_end_model.set_line(1'b0);
    repeat (2) u_far_end_model.push(3'b001);
    rdm(SP, 8'hff, 8'h01);
    rdm(LS, 8'h9f, 8'h91);
    u_far_end_model.set_line(1'b1);
    u_far_end_model.pop();
    rdm(LS, 8'h9f, 8'h00);
    wr(FC, 8'h00);
  endtask

  task automatic t_tx();
    fifo_enable <= 1'b0;
    rdm(LS, 8'h60, 8'h60);
    u_far_end_model.tx_pulse(3'b100);
    rdm(LS, 8'h60, 8'h00);
    u_far_end_model.set_tx(1'b1, 8'h00);
    u_far_end_model.tx_pulse(3'b010);
    rdm(LS, 8'h60, 8'h20);
    u_far_end_model.set_tx(1'b0, 8'h00);
    rdm(LS, 8'h60, 8'h60);
    fifo_enable <= 1'b1;
    u_far_end_model.set_tx(1'b0, 8'h03);
    rdm(LS, 8'h60, 8'h00);
    u_far_end_model.set_tx(1'b0, 8'h00);
    rdm(LS, 8'h60, 8'h60);
  endtask

  task automatic t_modem();
    wr(IE, 8'h08);
    bus(MS, 1'b0, 8'h00);
    u_far_end_model.set_pins(4'b0111);
    repeat (3) @(posedge hclk);
    chk(modem_irq, 1'b1);
    rdm(MS, 8'hff, 8'h11);
    rdm(MS, 8'hff, 8'h10);
    chk(modem_irq, 1'b0);
    u_far_end_model.set_pins(4'b0101);
    rdm(MS, 8'hff, 8'h50);
    u_far_end_model.set_pins(4'b0111);
    rdm(MS, 8'hff, 8'h14);
    u_far_end_model.set_pins(4'b0010);
    rdm(MS, 8'hff, 8'hba);
    u_far_end_model.set_pins(4'hf);
    bus(MS, 1'b0, 8'h00);
  endtask

  task automatic t_loop();
    wr(MC, 8'h1f);
    rdm(MS, 8'hf0, 8'hf0);
    chk({dtr_n, rts_n, op2_n, loopback_on}, 4'b1111);
    wr(MC, 8'h12);
    rdm(MS, 8'hf0, 8'h10);
    wr(MC, 8'h0b);
    rdm(MS, 8'hf0, 8'h00);
    chk({dtr_n, rts_n, op2_n, loopback_on}, 4'b0000);
    wr(MC, 8'h00);
    bus(MS, 1'b0, 8'h00);
  endtask

  task automatic t_prescale();
    int n;
    wr(MC, 8'h80);
    repeat (3) @(posedge hclk);
    ticks(n);
    chk(n, 2);
    wr(MC, 8'h00);
    repeat (3) @(posedge hclk);
    ticks(n);
    chk(n, 8);
  endtask

  task automatic t_hyst();
    for (int i = 0; i < 16; i++)
    begin
      wr(FC, {6'h10, i[1:0]});
      wr(SP, {2'b00, i[3:2], 4'h0});
      repeat (2) @(posedge hclk);
      chk(rts_hysteresis, hyst[i]);
      rdm(uart_status_pkg::ADDR_HYSTERESIS, 8'h3f, {2'b00, hyst[i]});
    end
    wr(FC, 8'h00);
  endtask

  task automatic t_cts();
    wr(EF, 8'h80);
    u_far_end_model.set_tx(1'b1, 8'h00);
    u_far_end_model.set_pins(4'b0111);
    repeat (3) @(posedge hclk);
    chk(tx_stop, 1'b0);
    u_far_end_model.set_pins(4'hf);
    repeat (3) @(posedge hclk);
    chk(tx_stop, 1'b0);
    u_far_end_model.tx_pulse(3'b001);
    repeat (2) @(posedge hclk);
    chk(tx_stop, 1'b1);
    u_far_end_model.set_pins(4'b0111);
    repeat (2) @(posedge hclk);
    chk(tx_stop, 1'b0);
    u_far_end_model.set_pins(4'hf);
    wr(EF, 8'h00);
  endtask

  // A reset in mid-run must bring the scratch byte back to all ones.
  task automatic t_reset();
    wr(SP, 8'h33);
    rdm(SP, 8'hff, 8'h33);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdm(SP, 8'hff, 8'hff);
  endtask

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0000_0000;
    fifo_enable = 1'b1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_rx();
    t_level();
    t_break();
    t_tx();
    t_modem();
    t_loop();
    t_prescale();
    t_hyst();
    t_cts();
    t_reset();
    wrap_up();
  end
endmodule
